// file: verilog/drive_status_monitor.sv
// status monitor and fault logging for a motor drive, APB slave
`timescale 1ns/1ps
`include "drive_status_map.svh"

// Overview of operation
// - user monitor shows volt, power, torque, analog V or analog I/V; label follows
// - analog I/V choice only on advanced I/O; current to 20 mA, volt 10 V
// - power-up item from select code 0 to 17, default 0 run frequency
// - codes 12-15 current, speed, DC bus, user monitor; 16 fault; 17 hidden
// - input terminal state, one bit each, 3 standard or 5 advanced
// - output terminal state, relay and open collector bits, 00 when off
// - trip captures fault type, frequency, current and phase
// - phase records accelerating, decelerating or constant speed
// - history keeps five fault records, entries 1 to 5
// - writing 1 to history clear erases all five entries
// - fault reset moves current fault to entry 1, older ones shift down
// - simultaneous trips stored together in one entry, one bit per source
module drive_status_monitor
    import drive_status_pkg::*;
#(
    parameter bit ADVANCED_IO = 1'b1,
    parameter int DEPTH       = `HISTORY_DEPTH
) (
    input  wire logic        pclk,           // system clock
    input  wire logic        presetn,        // async reset, low
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb enable
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire logic [15:0] out_voltage,    // output voltage sample
    input  wire logic [15:0] out_power,      // output power sample
    input  wire logic [15:0] torque,         // torque sample
    input  wire logic [15:0] analog_volt,    // analog voltage input
    input  wire logic [15:0] analog_curr,    // analog current/voltage input
    input  wire logic        analog_mode_switch, // 1 current mode, pin
    input  wire logic [4:0]  input_pins,     // input terminals, pins
    input  wire logic        relay_pin,      // relay output state
    input  wire logic        oc_pin,         // open collector state
    input  wire logic [15:0] run_freq,       // present output frequency
    input  wire logic [15:0] run_amps,       // present output current
    input  wire logic        accelerating,   // ramp up in progress
    input  wire logic        decelerating,   // ramp down in progress
    input  wire logic [3:0]  trip_req,       // trip sources, same cycle
    input  wire logic        stop_reset_key, // stop/reset key, pin
    input  wire logic        reset_terminal, // reset terminal, pin
    output logic [4:0]       powerup_item,   // item shown at power-up
    output logic [2:0]       user_label,     // label of user monitor
    output logic [15:0]      user_monitor_value, // selected quantity
    output logic             fault_active    // a trip is held
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]  mon_sel;
        logic [4:0]  pwr_sel;
        logic [4:0]  in_s1;
        logic [4:0]  in_s2;
        logic [1:0]  out_s1;
        logic [1:0]  out_s2;
        logic [2:0]  rst_s1;
        logic [2:0]  rst_s2;
        logic        rst_prev;
        logic        amode_s1;
        logic        amode_s2;
        logic        held;
        fault_rec_s  cur;
        logic [15:0] mon_val;
        logic [2:0]  label;
        logic [4:0]  pwr_item;
        logic        shift;
        logic        clear;
        logic        clr_bit;
        logic [31:0] rdata;
        logic        err;
    } state_s;

    state_s     st_q;
    state_s     st_d;
    fault_rec_s hist [DEPTH];

    localparam logic [11:0] HIST_END = 12'(`OFS_HISTORY_BASE + DEPTH * `OFS_HISTORY_STRIDE);

    // map history address to entry index and field
    function automatic logic [31:0] hist_read(input logic [11:0] a);
        logic [11:0] off;
        logic [3:0]  idx;
        hist_read = 32'h0000_0000;
        off       = a - `OFS_HISTORY_BASE;
        idx       = off[7:4];
        for (int i = 0; i < DEPTH; i++) begin
            if (idx == 4'(i)) begin
                case (off[3:2])
                    2'd0:    hist_read = {16'h0000, hist[i].fault};
                    2'd1:    hist_read = {16'h0000, hist[i].freq};
                    2'd2:    hist_read = {16'h0000, hist[i].amps};
                    default: hist_read = {30'h0000_0000, hist[i].phase};
                endcase
            end
        end
    endfunction

    // power-up item, out-of-range codes fall back to run frequency
    function automatic logic [4:0] pwr_item_of(input logic [4:0] s);
        pwr_item_of = (s > `POWERUP_SELECT_MAX) ? `POWERUP_SELECT_RST : s;
    endfunction

    wire logic setup  = psel && !penable;
    wire logic access = psel && penable;
    wire logic in_hist = (paddr >= `OFS_HISTORY_BASE) && (paddr < HIST_END);

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        logic       rst_now;
        logic [4:0] in_mask;
        rst_now = 1'b0;
        in_mask = 5'h00;
        st_d    = st_q;
        st_d.shift = 1'b0;
        st_d.clear = 1'b0;

        // two-flop synchronisers for pins
        st_d.in_s1    = input_pins;
        st_d.in_s2    = st_q.in_s1;
        st_d.out_s1   = {relay_pin, oc_pin};
        st_d.out_s2   = st_q.out_s1;
        st_d.rst_s1   = {stop_reset_key, reset_terminal, 1'b0};
        st_d.rst_s2   = st_q.rst_s1;
        st_d.amode_s1 = analog_mode_switch;
        st_d.amode_s2 = st_q.amode_s1;

        // fault reset request, rising edge of key or terminal
        rst_now       = st_q.rst_s2[2] | st_q.rst_s2[1];
        st_d.rst_prev = rst_now;

        // record stays one cycle past the shift so history takes it intact
        if (st_q.shift) begin
            st_d.cur = '0;
        end

        // capture the first trip cycle; all sources merged into one record
        if (!st_q.held && (trip_req != 4'h0)) begin
            st_d.held      = 1'b1;
            st_d.cur.fault = {12'h000, trip_req};
            st_d.cur.freq  = run_freq;
            st_d.cur.amps  = run_amps;
            if (accelerating) begin
                st_d.cur.phase = PHASE_ACCEL;
            end else if (decelerating) begin
                st_d.cur.phase = PHASE_DECEL;
            end else begin
                st_d.cur.phase = PHASE_CONST;
            end
        end else if (st_q.held && rst_now && !st_q.rst_prev) begin
            st_d.held  = 1'b0;
            st_d.shift = 1'b1;
        end

        // user monitor selection and label
        case (st_q.mon_sel)
            MON_OUT_VOLT: begin
                st_d.mon_val = out_voltage;
                st_d.label   = LBL_VOLT;
            end
            MON_OUT_POWER: begin
                st_d.mon_val = out_power;
                st_d.label   = LBL_POWER;
            end
            MON_TORQUE: begin
                st_d.mon_val = torque;
                st_d.label   = torque_label;
            end
            MON_AN_VOLT: begin
                st_d.mon_val = (analog_volt > `ANALOG_VOLT_FULL) ?
                               `ANALOG_VOLT_FULL : analog_volt;
                st_d.label   = analog_volt_label;
            end
            MON_AN_CURR: begin
                if (st_q.amode_s2) begin
                    st_d.mon_val = (analog_curr > `ANALOG_AMP_FULL) ?
                                   `ANALOG_AMP_FULL : analog_curr;
                    st_d.label   = analog_current_label;
                end else begin
                    st_d.mon_val = (analog_curr > `ANALOG_VOLT_FULL) ?
                                   `ANALOG_VOLT_FULL : analog_curr;
                    st_d.label   = LBL_ANALOG_V_MODE;
                end
            end
            default: begin
                st_d.mon_val = out_voltage;
                st_d.label   = LBL_VOLT;
            end
        endcase

        st_d.pwr_item = pwr_item_of(st_q.pwr_sel);

        // apb write, takes effect at the access edge
        if (access && pwrite) begin
            case (paddr)
                `OFS_MONITOR_SELECT: begin
                    if (pwdata[2:0] <= `MONITOR_SELECT_MAX &&
                        (ADVANCED_IO || pwdata[2:0] != MON_AN_CURR)) begin
                        st_d.mon_sel = pwdata[2:0];
                    end
                end
                `OFS_POWERUP_SELECT: begin
                    if (pwdata[4:0] <= `POWERUP_SELECT_MAX) begin
                        st_d.pwr_sel = pwdata[4:0];
                    end
                end
                `OFS_HISTORY_CLEAR: begin
                    st_d.clr_bit = pwdata[0];
                    st_d.clear   = pwdata[0];
                end
                default: begin
                end
            endcase
        end

        // read data and error, captured in setup so access answers at once
        in_mask = ADVANCED_IO ? 5'h1F : 5'h07;
        if (setup) begin
            st_d.err = 1'b0;
            case (paddr)
                `OFS_MONITOR_SELECT: st_d.rdata = {29'h0, st_q.mon_sel};
                `OFS_POWERUP_SELECT: st_d.rdata = {27'h0, st_q.pwr_sel};
                `OFS_INPUT_STATE:    st_d.rdata = {27'h0, st_q.in_s2 & in_mask};
                `OFS_OUTPUT_STATE:   st_d.rdata = {30'h0, st_q.out_s2};
                `OFS_USER_MONITOR:   st_d.rdata = {16'h0, st_q.mon_val};
                `OFS_USER_LABEL:     st_d.rdata = {29'h0, st_q.label};
                `OFS_POWERUP_ITEM:   st_d.rdata = {27'h0, st_q.pwr_item};
                `OFS_CURRENT_FAULT:  st_d.rdata = {16'h0, st_q.cur.fault};
                `OFS_CURRENT_FREQ:   st_d.rdata = {16'h0, st_q.cur.freq};
                `OFS_CURRENT_AMPS:   st_d.rdata = {16'h0, st_q.cur.amps};
                `OFS_CURRENT_PHASE:  st_d.rdata = {30'h0, st_q.cur.phase};
                `OFS_HISTORY_CLEAR:  st_d.rdata = {31'h0, st_q.clr_bit};
                default: begin
                    if (in_hist) begin
                        st_d.rdata = hist_read(paddr);
                    end else begin
                        st_d.rdata = 32'h0000_0000;
                        st_d.err   = 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q         <= '0;
            st_q.mon_sel <= `MONITOR_SELECT_RST;
            st_q.pwr_sel <= `POWERUP_SELECT_RST;
            st_q.in_s1   <= `INPUT_STATE_RST;
            st_q.in_s2   <= `INPUT_STATE_RST;
            st_q.clr_bit <= `HISTORY_CLEAR_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // history and outputs
    // ****************************************
    fault_history #(
        .DEPTH (DEPTH)
    ) u_hist (
        .pclk    (pclk),
        .presetn (presetn),
        .shift_i (st_q.shift),
        .clear_i (st_q.clear),
        .rec_i   (st_q.cur),
        .hist_o  (hist)
    );

    // apb answers in the first access cycle
    assign pready             = 1'b1;
    assign prdata             = st_q.rdata;
    assign pslverr            = access && st_q.err;
    assign powerup_item       = st_q.pwr_item;
    assign user_label         = st_q.label;
    assign user_monitor_value = st_q.mon_val;
    assign fault_active       = st_q.held;

    // ****************************************
    // assertions
    // ****************************************
    a_trip_capture: assert property (@(posedge pclk) disable iff (!presetn)
        !st_q.held && trip_req != 4'h0 |=> st_q.held && st_q.cur.freq == $past(run_freq))
        else $error("trip not captured");

    a_phase_accel: assert property (@(posedge pclk) disable iff (!presetn)
        !st_q.held && trip_req != 4'h0 && accelerating |=> st_q.cur.phase == PHASE_ACCEL)
        else $error("accel phase wrong");

    a_merge_trips: assert property (@(posedge pclk) disable iff (!presetn)
        !st_q.held && trip_req != 4'h0 |=> st_q.cur.fault[3:0] == $past(trip_req))
        else $error("simultaneous trips not merged");

    a_mon_torque: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.mon_sel == MON_TORQUE ##1 st_q.mon_sel == MON_TORQUE |-> user_label == torque_label)
        else $error("torque label missing");

    a_pwr_item: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(st_q.pwr_sel) |=> powerup_item == $past(st_q.pwr_sel))
        else $error("power-up item mismatch");

    a_shift_on_reset: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.shift |-> !st_q.held ##1 hist[0].fault == $past(st_q.cur.fault))
        else $error("fault reset did not shift");

    a_input_width: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == `OFS_INPUT_STATE && !ADVANCED_IO |=> prdata[4:3] == 2'b00)
        else $error("standard input state too wide");

    a_output_off: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == `OFS_OUTPUT_STATE && st_q.out_s2 == 2'b00 |=> prdata == 32'h0)
        else $error("output state not 00");

    a_mon_power: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.mon_sel == MON_OUT_POWER |=> user_monitor_value == $past(out_power))
        else $error("power value wrong");

    a_analog_clamp: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.mon_sel == MON_AN_CURR |=> user_monitor_value <= `ANALOG_AMP_FULL)
        else $error("analog not clamped");

    a_trip_kept: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.held ##1 st_q.held |-> $stable(st_q.cur))
        else $error("held record changed");

    a_cur_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.shift && trip_req == 4'h0 |=> st_q.cur.fault == `FAULT_NONE)
        else $error("record not cleared");

endmodule

// file: pkg/drive_status_map.svh
// register offsets, field layouts and reset values for the drive status monitor
`ifndef DRIVE_STATUS_MAP_SVH
`define DRIVE_STATUS_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_MONITOR_SELECT     12'h000
`define OFS_POWERUP_SELECT     12'h004
`define OFS_INPUT_STATE        12'h008
`define OFS_OUTPUT_STATE       12'h00C
`define OFS_USER_MONITOR       12'h010
`define OFS_USER_LABEL         12'h014
`define OFS_POWERUP_ITEM       12'h018
`define OFS_CURRENT_FAULT      12'h01C
`define OFS_CURRENT_FREQ       12'h020
`define OFS_CURRENT_AMPS       12'h024
`define OFS_CURRENT_PHASE      12'h028
`define OFS_HISTORY_CLEAR      12'h02C
`define OFS_HISTORY_BASE       12'h040
`define OFS_HISTORY_STRIDE     12'h010

// ****************************************
// widths and reset values
// ****************************************
`define MONITOR_SELECT_W       3
`define POWERUP_SELECT_W       5
`define MONITOR_SELECT_RST     3'h0
`define POWERUP_SELECT_RST     5'h00
`define MONITOR_SELECT_MAX     3'h4
`define POWERUP_SELECT_MAX     5'h11
`define HISTORY_CLEAR_RST      1'b0
`define INPUT_STATE_RST        5'h01
`define FAULT_NONE             16'h0000
`define HISTORY_DEPTH          5
`define PHASE_W                2
`define ANALOG_VOLT_FULL       16'h03E8
`define ANALOG_AMP_FULL        16'h07D0

`endif

// file: pkg/drive_status_pkg.sv
// types shared by the drive status monitor
package drive_status_pkg;

    // item shown on the user monitor
    typedef enum logic [2:0] {
        MON_OUT_VOLT  = 3'b000,
        MON_OUT_POWER = 3'b001,
        MON_TORQUE    = 3'b010,
        MON_AN_VOLT   = 3'b011,
        MON_AN_CURR   = 3'b100
    } monitor_sel_e;

    // operating phase at trip
    typedef enum logic [1:0] {
        PHASE_CONST = 2'b00,
        PHASE_ACCEL = 2'b01,
        PHASE_DECEL = 2'b10
    } op_phase_e;

    // label codes for the user monitor display
    typedef enum logic [2:0] {
        LBL_VOLT         = 3'b000,
        LBL_POWER        = 3'b001,
        torque_label     = 3'b010,
        analog_volt_label = 3'b011,
        analog_current_label = 3'b100,
        LBL_ANALOG_V_MODE = 3'b101
    } monitor_label_e;

    // one fault record
    typedef struct packed {
        logic [15:0] fault;
        logic [15:0] freq;
        logic [15:0] amps;
        logic [1:0]  phase;
    } fault_rec_s;

endpackage

// file: verilog/fault_history.sv
// five-deep fault history shift register
`timescale 1ns/1ps
`include "drive_status_map.svh"

module fault_history
    import drive_status_pkg::*;
#(
    parameter int DEPTH = `HISTORY_DEPTH
) (
    input  wire logic       pclk,          // system clock
    input  wire logic       presetn,       // async reset, low
    input  wire logic       shift_i,       // fault reset pulse
    input  wire logic       clear_i,       // erase pulse
    input  wire fault_rec_s rec_i,         // current fault record
    output fault_rec_s      hist_o [DEPTH] // entry 1 at index 0
);

    typedef struct packed {
        fault_rec_s [DEPTH-1:0] ent;
    } hist_state_s;

    hist_state_s st_q;
    hist_state_s st_d;

    localparam fault_rec_s EMPTY = '{fault: `FAULT_NONE, freq: 16'h0000,
                                     amps: 16'h0000, phase: 2'b00};

    // shift toward the oldest entry, oldest drops out; clear empties all
    always_comb begin
        st_d = st_q;
        if (clear_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                st_d.ent[i] = EMPTY;
            end
        end else if (shift_i) begin
            st_d.ent[0] = rec_i;
            for (int i = 1; i < DEPTH; i++) begin
                st_d.ent[i] = st_q.ent[i-1];
            end
        end
    end

    // register the history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // unpack entries to the output array
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_out
            assign hist_o[g] = st_q.ent[g];
        end
    endgenerate

    // ****************************************
    // assertions
    // ****************************************
    a_shift_newest: assert property (@(posedge pclk) disable iff (!presetn)
        shift_i && !clear_i |=> st_q.ent[0] == $past(rec_i))
        else $error("entry 1 did not take the current fault");

    a_shift_older: assert property (@(posedge pclk) disable iff (!presetn)
        shift_i && !clear_i |=> st_q.ent[DEPTH-1] == $past(st_q.ent[DEPTH-2]))
        else $error("history did not shift");

    a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
        clear_i |=> st_q.ent[0].fault == `FAULT_NONE && st_q.ent[DEPTH-1].fault == `FAULT_NONE)
        else $error("history not erased");

endmodule

// file: dv/drive_side_model.sv
// behavioural model of the keypad and the trip detection side
`timescale 1ns/1ps

module drive_side_model (
    input  wire logic        pclk,           // system clock
    output logic      [3:0]  trip_req,       // trip sources
    output logic             stop_reset_key, // stop/reset key
    output logic             reset_terminal, // reset terminal
    output logic             accelerating,   // ramp up
    output logic             decelerating,   // ramp down
    output logic      [15:0] run_freq,       // output frequency
    output logic      [15:0] run_amps        // output current
);
    // idle levels at time zero
    initial begin
        trip_req = 4'h0;
        stop_reset_key = 1'b0;
        reset_terminal = 1'b0;
        accelerating = 1'b0;
        decelerating = 1'b0;
        run_freq = 16'h0000;
        run_amps = 16'h0000;
    end

    // one-cycle trip with the ramp state, then the live values move on
    task automatic trip(input logic [3:0] m, input logic [1:0] ph,
                        input logic [15:0] f, input logic [15:0] a);
        @(posedge pclk);
        trip_req     <= m;
        accelerating <= (ph == 2'h1);
        decelerating <= (ph == 2'h2);
        run_freq     <= f;
        run_amps     <= a;
        @(posedge pclk);
        trip_req <= 4'h0;
        repeat (3) @(posedge pclk);
        accelerating <= 1'b0;
        decelerating <= 1'b0;
        run_freq     <= ~f; // live value no longer the trip value
        run_amps     <= ~a;
    endtask

    // operator fault reset by key or by terminal
    task automatic fault_reset(input logic use_term);
        @(posedge pclk);
        if (use_term) begin
            reset_terminal <= 1'b1;
        end else begin
            stop_reset_key <= 1'b1;
        end
        repeat (3) @(posedge pclk);
        reset_terminal <= 1'b0;
        stop_reset_key <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// file: dv/drive_status_monitor_tb_top.sv
// self-checking testbench for the drive status monitor
`timescale 1ns/1ps
`include "drive_status_map.svh"

module drive_status_monitor_tb_top;
    import drive_status_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic        mode_sw, relay, oc, fault_active, acc, dec, key, term;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] smp [5];
    logic [15:0] freq, amps, umon;
    logic [4:0]  pins, pitem;
    logic [3:0]  trips;
    logic [2:0]  label;
    int          n_fail, comparisons;

    drive_status_monitor drive_status_monitor_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .out_voltage(smp[0]), .out_power(smp[1]), .torque(smp[2]), .analog_volt(smp[3]),
        .analog_curr(smp[4]), .analog_mode_switch(mode_sw), .input_pins(pins),
        .relay_pin(relay), .oc_pin(oc), .run_freq(freq), .run_amps(amps),
        .accelerating(acc), .decelerating(dec), .trip_req(trips), .stop_reset_key(key),
        .reset_terminal(term), .powerup_item(pitem), .user_label(label),
        .user_monitor_value(umon), .fault_active(fault_active));

    drive_side_model drive_side_model_i (
        .pclk(pclk), .trip_req(trips), .stop_reset_key(key), .reset_terminal(term),
        .accelerating(acc), .decelerating(dec), .run_freq(freq), .run_amps(amps));

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(r, e);
    endtask

    function automatic logic [11:0] hist(input int n);
        return `OFS_HISTORY_BASE + `OFS_HISTORY_STRIDE * 12'(n);
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_vals;
        rd(`OFS_MONITOR_SELECT, 0);
        rd(`OFS_POWERUP_SELECT, 0);
        chk(32'(pitem), 0);
        rd(`OFS_OUTPUT_STATE, 0);
        rd(`OFS_HISTORY_CLEAR, 0);
    endtask

    task automatic t_monitor;
        logic [2:0] lb [5] = '{LBL_VOLT, LBL_POWER, torque_label, analog_volt_label,
                               analog_current_label};
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_MONITOR_SELECT, 32'(i));
            repeat (3) @(posedge pclk);
            rd(`OFS_USER_MONITOR, 32'h0011 * (i + 1));
            rd(`OFS_USER_LABEL, 32'(lb[i]));
            chk(32'(label), 32'(lb[i]));
            chk(32'(umon), 32'h0011 * (i + 1));
        end
        wr(`OFS_MONITOR_SELECT, 32'h0000_0005);
        rd(`OFS_MONITOR_SELECT, 4);
    endtask

    task automatic t_analog;
        smp[4] <= 16'hFFFF;
        repeat (3) @(posedge pclk);
        rd(`OFS_USER_MONITOR, `ANALOG_AMP_FULL);
        mode_sw <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(`OFS_USER_MONITOR, `ANALOG_VOLT_FULL);
        rd(`OFS_USER_LABEL, 32'(LBL_ANALOG_V_MODE));
    endtask

    task automatic t_powerup;
        for (int c = 12; c < 18; c++) begin
            wr(`OFS_POWERUP_SELECT, 32'(c));
            repeat (2) @(posedge pclk);
            rd(`OFS_POWERUP_ITEM, 32'(c));
            chk(32'(pitem), 32'(c));
        end
        wr(`OFS_POWERUP_SELECT, 32'h0000_0012);
        rd(`OFS_POWERUP_SELECT, 17);
    endtask

    task automatic t_terminals;
        pins <= 5'h16;
        relay <= 1'b1;
        oc <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`OFS_INPUT_STATE, 32'h0000_0016);
        rd(`OFS_OUTPUT_STATE, 3);
        pins <= 5'h09;
        relay <= 1'b0;
        oc <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(`OFS_INPUT_STATE, 9);
        rd(`OFS_OUTPUT_STATE, 0);
    endtask

    task automatic t_faults;
        logic [3:0] m [6] = '{4'h1, 4'h2, 4'hA, 4'h4, 4'h8, 4'h3};
        for (int n = 0; n < 5; n++) rd(hist(n), 0);
        for (int k = 0; k < 6; k++) begin
            drive_side_model_i.trip(m[k], 2'(k % 3), 16'h1000 + 16'(k), 16'h0200 + 16'(k));
            chk(32'(fault_active), 1);
            rd(`OFS_CURRENT_FAULT, 32'(m[k]));
            rd(`OFS_CURRENT_FREQ, 32'h1000 + k);
            rd(`OFS_CURRENT_AMPS, 32'h0200 + k);
            rd(`OFS_CURRENT_PHASE, 32'(k % 3));
            drive_side_model_i.fault_reset(k[0]);
            chk(32'(fault_active), 0);
            for (int n = 0; n < 5; n++) begin
                rd(hist(n), (n <= k) ? 32'(m[k - n]) : 0);
                rd(hist(n) + 12'h004, (n <= k) ? 32'h1000 + k - n : 0);
            end
        end
        rd(hist(0) + 12'h00C, 2);
        rd(hist(1) + 12'h00C, 1);
    endtask

    task automatic t_clear;
        wr(`OFS_HISTORY_CLEAR, 1);
        repeat (3) @(posedge pclk);
        rd(`OFS_HISTORY_CLEAR, 1);
        for (int n = 0; n < 5; n++) rd(hist(n), 0);
        wr(`OFS_HISTORY_CLEAR, 0);
    endtask

    task automatic t_unmapped;
        rd(12'h030, 0);
        chk(32'(last_err), 1);
    endtask

    // ****************************************
    // clock, verdict, watchdog and main sequence
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        results;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {relay, oc, pins, last_err} = '0;
        mode_sw = 1'b1;
        for (int i = 0; i < 5; i++) smp[i] = 16'h0011 * 16'(i + 1);
        n_fail = 0;
        comparisons = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals;
        t_monitor;
        t_analog;
        t_powerup;
        t_terminals;
        t_faults;
        t_clear;
        t_unmapped;
        results;
    end
endmodule
